// file: hw/cacr_top.sv
// Counter high snapshot and the capture/compare byte registers of six modules on the SFR port
`timescale 1ns/1ps
`default_nettype none
module cacr_top
  import cacr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // SFR port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rd_valid,
  // Counter side
  input wire logic [15:0] counter_value,
  input wire logic counter_low_rd,
  input wire logic watchdog_enable_bit,
  output logic counter_high_wr,
  output logic [7:0] counter_high_wdata,
  // Configuration from the mode and PWM registers
  input wire logic reload_select_bit,
  input wire logic [CACR_MODULES-1:0] mode_enable_load,
  input wire logic [CACR_MODULES-1:0] mode_enable_value,
  // Module state
  output logic [CACR_MODULES-1:0] comparator_enable_bit,
  output logic [CACR_MODULES-1:0][15:0] compare_value,
  output logic [CACR_MODULES-1:0][15:0] reload_value,
  output logic [CACR_MODULES-1:0] match
);

  import cacr_pkg::*;

  logic page_ok;
  cacr_slot_sel_t wr_sel;
  cacr_slot_sel_t rd_sel;
  logic [CACR_MODULES-1:0] wr_low_vec;
  logic [CACR_MODULES-1:0] wr_high_vec;
  logic [7:0] snapshot_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic high_wr_reg;
  logic [7:0] high_wdata_reg;

  assign page_ok = (sfr_page == CACR_SFR_PAGE);
  assign wr_sel = cacr_decode(sfr_addr);
  assign rd_sel = cacr_decode(sfr_addr);

  // Byte write strobes per module
  genvar gi;
  generate
    for (gi = 0; gi < CACR_MODULES; gi++) begin : g_mod
      assign wr_low_vec[gi] = sfr_wr && page_ok && wr_sel.hit && !wr_sel.high && (wr_sel.index == 3'(gi));
      assign wr_high_vec[gi] = sfr_wr && page_ok && wr_sel.hit && wr_sel.high && (wr_sel.index == 3'(gi));

      cacr_slot cacr_slot_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_low(wr_low_vec[gi]),
        .wr_high(wr_high_vec[gi]),
        .reload_select_bit(reload_select_bit),
        .wdata(sfr_wdata),
        .enable_load(mode_enable_load[gi]),
        .enable_value(mode_enable_value[gi]),
        .compare_value(compare_value[gi]),
        .reload_value(reload_value[gi]),
        .comparator_enable_bit(comparator_enable_bit[gi])
      );

      cacr_match cacr_match_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .counter_value(counter_value),
        .compare_value(compare_value[gi]),
        .comparator_enable_bit(comparator_enable_bit[gi]),
        .match(match[gi])
      );
    end
  endgenerate

  // snapshot load on low byte read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snapshot_reg <= CACR_BYTE_RESET;
    end else if (counter_low_rd) begin
      snapshot_reg <= counter_value[15:8];
    end
  end

  // high byte write blocked by watchdog
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_wr_reg <= 1'b0;
      high_wdata_reg <= CACR_BYTE_RESET;
    end else begin
      high_wr_reg <= sfr_wr && page_ok && (sfr_addr == CACR_COUNTER_HIGH_SNAPSHOT) && !watchdog_enable_bit;
      if (sfr_wr && page_ok && (sfr_addr == CACR_COUNTER_HIGH_SNAPSHOT) && !watchdog_enable_bit) begin
        high_wdata_reg <= sfr_wdata;
      end
    end
  end

  always_comb begin
    rdata_next = CACR_UNMAPPED_READ;
    if (page_ok) begin
      if (sfr_addr == CACR_COUNTER_HIGH_SNAPSHOT) begin
        rdata_next = snapshot_reg;
      end else if (rd_sel.hit) begin
        case ({reload_select_bit, rd_sel.high})
          2'b00: rdata_next = compare_value[rd_sel.index][7:0];
          2'b01: rdata_next = compare_value[rd_sel.index][15:8];
          2'b10: rdata_next = reload_value[rd_sel.index][7:0];
          2'b11: rdata_next = reload_value[rd_sel.index][15:8];
          default: rdata_next = CACR_UNMAPPED_READ;
        endcase
      end
    end
  end

  // Registered read answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= CACR_BYTE_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= sfr_rd;
      if (sfr_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign sfr_rdata = rdata_reg;
  assign sfr_rd_valid = rd_valid_reg;
  assign counter_high_wr = high_wr_reg;
  assign counter_high_wdata = high_wdata_reg;

endmodule // cacr_top
`default_nettype wire

// file: hw/cacr_pkg.sv
// Constants and address decoding shared by the counter array capture register block
// Contract
// - High byte read returns snapshot, not live
// - Snapshot loads only on low byte read
// - Watchdog enabled blocks counter high writes
// - Six low compare bytes, reset zero
// - Low address reaches compare or reload
// - Low byte write clears comparator enable
// - Six high compare bytes, reset zero
// - High address reaches compare or reload
// - High byte write sets comparator enable
// - Comparator matches only while enabled
`default_nettype none
package cacr_pkg;

  localparam int CACR_MODULES = 6;
  localparam logic [7:0] CACR_SFR_PAGE = 8'h00;

  // Register addresses
  localparam logic [7:0] CACR_COUNTER_HIGH_SNAPSHOT = 8'hfa;
  localparam logic [7:0] CACR_MODULE0_COMPARE_LOW = 8'hfb;
  localparam logic [7:0] CACR_MODULE0_COMPARE_HIGH = 8'hfc;
  localparam logic [7:0] CACR_MODULE1_COMPARE_LOW = 8'he9;
  localparam logic [7:0] CACR_MODULE1_COMPARE_HIGH = 8'hea;
  localparam logic [7:0] CACR_MODULE2_COMPARE_LOW = 8'heb;
  localparam logic [7:0] CACR_MODULE2_COMPARE_HIGH = 8'hec;
  localparam logic [7:0] CACR_MODULE3_COMPARE_LOW = 8'hed;
  localparam logic [7:0] CACR_MODULE3_COMPARE_HIGH = 8'hee;
  localparam logic [7:0] CACR_MODULE4_COMPARE_LOW = 8'hfd;
  localparam logic [7:0] CACR_MODULE4_COMPARE_HIGH = 8'hfe;
  localparam logic [7:0] CACR_MODULE5_COMPARE_LOW = 8'hce;
  localparam logic [7:0] CACR_MODULE5_COMPARE_HIGH = 8'hcf;

  // Reset values
  localparam logic [7:0] CACR_BYTE_RESET = 8'h00;
  localparam logic CACR_ENABLE_RESET = 1'b0;
  localparam logic [7:0] CACR_UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic hit;
    logic high;
    logic [2:0] index;
  } cacr_slot_sel_t;

  // Maps an address to a module byte slot
  function automatic cacr_slot_sel_t cacr_decode(input logic [7:0] addr);
    cacr_slot_sel_t sel;
    sel = '{hit: 1'b1, high: 1'b0, index: 3'h0};
    case (addr)
      CACR_MODULE0_COMPARE_LOW: sel = '{1'b1, 1'b0, 3'h0};
      CACR_MODULE0_COMPARE_HIGH: sel = '{1'b1, 1'b1, 3'h0};
      CACR_MODULE1_COMPARE_LOW: sel = '{1'b1, 1'b0, 3'h1};
      CACR_MODULE1_COMPARE_HIGH: sel = '{1'b1, 1'b1, 3'h1};
      CACR_MODULE2_COMPARE_LOW: sel = '{1'b1, 1'b0, 3'h2};
      CACR_MODULE2_COMPARE_HIGH: sel = '{1'b1, 1'b1, 3'h2};
      CACR_MODULE3_COMPARE_LOW: sel = '{1'b1, 1'b0, 3'h3};
      CACR_MODULE3_COMPARE_HIGH: sel = '{1'b1, 1'b1, 3'h3};
      CACR_MODULE4_COMPARE_LOW: sel = '{1'b1, 1'b0, 3'h4};
      CACR_MODULE4_COMPARE_HIGH: sel = '{1'b1, 1'b1, 3'h4};
      CACR_MODULE5_COMPARE_LOW: sel = '{1'b1, 1'b0, 3'h5};
      CACR_MODULE5_COMPARE_HIGH: sel = '{1'b1, 1'b1, 3'h5};
      default: sel = '{1'b0, 1'b0, 3'h0};
    endcase
    return sel;
  endfunction

endpackage
`default_nettype wire

// file: hw/cacr_slot.sv
// One module's compare and auto-reload bytes with its comparator enable
`timescale 1ns/1ps
`default_nettype none
module cacr_slot
  import cacr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Byte writes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic reload_select_bit,
  input wire logic [7:0] wdata,
  // Enable load from the mode register
  input wire logic enable_load,
  input wire logic enable_value,
  // Stored state
  output logic [15:0] compare_value,
  output logic [15:0] reload_value,
  output logic comparator_enable_bit
);

  logic [7:0] compare_low_reg;
  logic [7:0] compare_high_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic enable_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_low_reg <= CACR_BYTE_RESET;
      reload_low_reg <= CACR_BYTE_RESET;
    end else if (wr_low) begin
      if (reload_select_bit) begin
        reload_low_reg <= wdata;
      end else begin
        compare_low_reg <= wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_high_reg <= CACR_BYTE_RESET;
      reload_high_reg <= CACR_BYTE_RESET;
    end else if (wr_high) begin
      if (reload_select_bit) begin
        reload_high_reg <= wdata;
      end else begin
        compare_high_reg <= wdata;
      end
    end
  end

  // enable side effects win over mode load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= CACR_ENABLE_RESET;
    end else if (wr_high) begin
      enable_reg <= 1'b1;
    end else if (wr_low) begin
      enable_reg <= 1'b0;
    end else if (enable_load) begin
      enable_reg <= enable_value;
    end
  end

  assign compare_value = {compare_high_reg, compare_low_reg};
  assign reload_value = {reload_high_reg, reload_low_reg};
  assign comparator_enable_bit = enable_reg;

endmodule // cacr_slot
`default_nettype wire

// file: hw/cacr_match.sv
// Registered comparator of the live counter against one compare value
`timescale 1ns/1ps
`default_nettype none
module cacr_match (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Compare inputs
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_value,
  input wire logic comparator_enable_bit,
  // Match pulse
  output logic match
);

  logic match_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= comparator_enable_bit && (counter_value == compare_value);
    end
  end

  assign match = match_reg;

endmodule // cacr_match
`default_nettype wire

// file: tb/cacr_chk.sv
// Assertion checker for the counter array capture registers
`timescale 1ns/1ps
`default_nettype none
module cacr_chk
  import cacr_pkg::*;
(
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [15:0] counter_value,
  input wire logic counter_low_rd,
  input wire logic watchdog_enable_bit,
  input wire logic counter_high_wr,
  input wire logic reload_select_bit,
  input wire logic [cacr_pkg::CACR_MODULES-1:0] mode_enable_load,
  input wire logic [cacr_pkg::CACR_MODULES-1:0] comparator_enable_bit,
  input wire logic [cacr_pkg::CACR_MODULES-1:0][15:0] compare_value,
  input wire logic [cacr_pkg::CACR_MODULES-1:0][15:0] reload_value,
  input wire logic [cacr_pkg::CACR_MODULES-1:0] match
);
  logic pg;
  logic wl;
  logic wh;
  logic rs;
  assign pg = sfr_page == CACR_SFR_PAGE;
  assign wl = sfr_wr && pg && sfr_addr == CACR_MODULE0_COMPARE_LOW;
  assign wh = sfr_wr && pg && sfr_addr == CACR_MODULE0_COMPARE_HIGH;
  assign rs = sfr_rd && pg && sfr_addr == CACR_COUNTER_HIGH_SNAPSHOT;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_SNAP: assert property (counter_low_rd ##1 !counter_low_rd ##1 (rs && !counter_low_rd)
    |=> sfr_rdata == $past(counter_value[15:8], 3)) else $error("snapshot read wrong");
  AST_WDOG: assert property (sfr_wr && pg && sfr_addr == CACR_COUNTER_HIGH_SNAPSHOT && watchdog_enable_bit
    |=> !counter_high_wr) else $error("high byte written under watchdog");
  AST_LOW_DATA: assert property (wl && !reload_select_bit |=> compare_value[0][7:0] == $past(sfr_wdata))
    else $error("low compare byte not stored");
  AST_LOW_CLR: assert property (wl |=> !comparator_enable_bit[0]) else $error("low write kept enable");
  AST_HIGH_RLD: assert property (wh && reload_select_bit |=> reload_value[0][15:8] == $past(sfr_wdata))
    else $error("high reload byte not stored");
  AST_HIGH_SET: assert property (wh |=> comparator_enable_bit[0]) else $error("high write left enable off");
  AST_MATCH: assert property (counter_value == compare_value[0] && comparator_enable_bit[0] |=> match[0])
    else $error("missed match");
  AST_NO_MATCH: assert property (!comparator_enable_bit[0] |=> !match[0]) else $error("match while disabled");
  AST_RD_QUIET: assert property (sfr_rd && mode_enable_load == '0 |=> $stable(comparator_enable_bit)
    && $stable(compare_value)) else $error("read disturbed state");
  cover property (wl ##1 wh);
  cover property (counter_low_rd ##2 rs);
  cover property (match[0] ##1 !match[0]);
endmodule // cacr_chk
bind cacr_top cacr_chk cacr_chk_inst (.ref_clk, .rst_n, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .counter_value, .counter_low_rd, .watchdog_enable_bit, .counter_high_wr, .reload_select_bit,
  .mode_enable_load, .comparator_enable_bit, .compare_value, .reload_value, .match);
`default_nettype wire

// file: tb/tb_cacr_top.sv
// Self-checking bench for the counter array capture registers
`timescale 1ns/1ps
`default_nettype none
module tb_cacr_top;
  import cacr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata, counter_high_wdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, counter_low_rd = 1'b0, watchdog_enable_bit = 1'b0;
  logic reload_select_bit = 1'b0, sfr_rd_valid, counter_high_wr;
  logic [15:0] counter_value = 16'h0000;
  logic [5:0] mode_enable_load = 6'h00, mode_enable_value = 6'h00, comparator_enable_bit, match;
  logic [5:0][15:0] compare_value, reload_value;
  logic [7:0] lo [6] = '{CACR_MODULE0_COMPARE_LOW, CACR_MODULE1_COMPARE_LOW, CACR_MODULE2_COMPARE_LOW,
    CACR_MODULE3_COMPARE_LOW, CACR_MODULE4_COMPARE_LOW, CACR_MODULE5_COMPARE_LOW};
  logic [7:0] hi [6] = '{CACR_MODULE0_COMPARE_HIGH, CACR_MODULE1_COMPARE_HIGH, CACR_MODULE2_COMPARE_HIGH,
    CACR_MODULE3_COMPARE_HIGH, CACR_MODULE4_COMPARE_HIGH, CACR_MODULE5_COMPARE_HIGH};
  int n_mismatch = 0;
  int n_checks = 0;
  cacr_top cacr_top_inst (.ref_clk, .rst_n, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .sfr_rd_valid, .counter_value, .counter_low_rd, .watchdog_enable_bit, .counter_high_wr, .counter_high_wdata,
    .reload_select_bit, .mode_enable_load, .mode_enable_value, .comparator_enable_bit, .compare_value,
    .reload_value, .match);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle, strobes dropped again at the next negedge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({7'h00, sfr_rd_valid, sfr_rdata}, {8'h01, e});
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      chk(compare_value[i] | reload_value[i], 16'h0000);
      rd(lo[i], 8'h00);
      rd(hi[i], 8'h00);
    end
    chk(16'(comparator_enable_bit), 16'h0000);
    chk(16'({match, counter_high_wr, counter_high_wdata}), 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_bytes();
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 8'(i);
      reload_select_bit = 1'b0;
      acc(1'b1, lo[i], v + 8'h10);
      chk(compare_value[i], {8'h00, v + 8'h10});
      chk(16'(comparator_enable_bit[i]), 16'h0000);
      acc(1'b1, hi[i], v + 8'ha0);
      chk(compare_value[i], {v + 8'ha0, v + 8'h10});
      chk(16'(comparator_enable_bit[i]), 16'h0001);
      rd(lo[i], v + 8'h10);
      reload_select_bit = 1'b1;
      acc(1'b1, lo[i], v + 8'h50);
      acc(1'b1, hi[i], v + 8'h60);
      chk(reload_value[i], {v + 8'h60, v + 8'h50});
      rd(hi[i], v + 8'h60);
      chk(compare_value[i], {v + 8'ha0, v + 8'h10});
    end
    reload_select_bit = 1'b0;
    $display("byte test done");
  endtask
  task automatic t_snap();
    counter_value = 16'hab12;
    @(negedge ref_clk);
    counter_low_rd = 1'b1;
    @(negedge ref_clk);
    counter_low_rd = 1'b0;
    counter_value = 16'h3456;
    rd(CACR_COUNTER_HIGH_SNAPSHOT, 8'hab);
    rd(CACR_COUNTER_HIGH_SNAPSHOT, 8'hab);
    $display("snapshot test done");
  endtask
  task automatic t_wdog();
    watchdog_enable_bit = 1'b1;
    acc(1'b1, CACR_COUNTER_HIGH_SNAPSHOT, 8'h5a);
    chk(16'(counter_high_wr), 16'h0000);
    watchdog_enable_bit = 1'b0;
    acc(1'b1, CACR_COUNTER_HIGH_SNAPSHOT, 8'h5a);
    chk({counter_high_wr, counter_high_wdata}, 16'h015a);
    sfr_page = 8'h01;
    acc(1'b1, lo[0], 8'hff);
    sfr_page = 8'h00;
    chk(compare_value[0], 16'ha010);
    rd(8'h00, 8'h00);
    $display("watchdog test done");
  endtask
  task automatic t_match();
    counter_value = 16'ha010;
    repeat (2) @(negedge ref_clk);
    chk(16'(match[0]), 16'h0001);
    acc(1'b1, lo[0], 8'h10);
    @(negedge ref_clk);
    chk(16'(match[0]), 16'h0000);
    mode_enable_load = 6'h01;
    mode_enable_value = 6'h01;
    @(negedge ref_clk);
    mode_enable_load = 6'h00;
    @(negedge ref_clk);
    chk(16'(match[0]), 16'h0001);
    $display("match test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_bytes();
    t_snap();
    t_wdog();
    t_match();
    conclude();
  end
endmodule // tb_cacr_top
`default_nettype wire
